// >>> baud_gen.sv
/*
  rate generator: one tick per sixteenth of a bit.
  assumes: divisor and fixed come from the core on mclk.
*/
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module baud_gen (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  baud_if.gen b
);
  typedef struct packed {
    logic [7:0] cnt; // cycles left in this tick
    logic tick;
  } rate_t;
  rate_t st, nx;

  // ----------------------------------------
  // divide by divisor + 1
  // ----------------------------------------
  always_comb begin
    nx = st;
    nx.tick = 1'b0;
    if (b.fixed || st.cnt == 8'h00) begin
      // fixed rate ignores the divisor [R6]
      nx.tick = 1'b1;
      nx.cnt = b.fixed ? 8'h00 : b.divisor; // [R5]
    end else begin
      nx.cnt = st.cnt - 8'h01;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= '0;
    end else if (clk_en) begin
      st <= nx;
    end
  end

  assign b.tick = st.tick & clk_en;

  property p_fixed_rate;
    @(posedge mclk) disable iff (!reset_n)
    (b.fixed && clk_en) |=> st.tick;
  endproperty
  a_fixed_rate: assert property (p_fixed_rate) else $error("fixed rate missed a tick"); // [R6]
endmodule // baud_gen

// >>> baud_if.sv
/*
  carrier between the port core and its rate generator.
  assumes: both ends run on mclk.
*/
`timescale 1ns/1ps
interface baud_if;
  logic [7:0] divisor; // rate divisor value
  logic fixed; // fixed divide-by-16 rate
  logic tick; // one pulse per sixteenth of a bit
  modport gen(input divisor, input fixed, output tick);
  modport user(output divisor, output fixed, input tick);
endinterface // baud_if

// >>> line_sync.sv
/*
  three-stage synchroniser with agreement filter for one pin.
  assumes: pin is asynchronous to mclk; idles high.
*/
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module line_sync (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire logic pin_in,
  output logic line_out
);
  typedef struct packed {
    logic s1; // metastable stage, only s2 reads it
    logic s2;
    logic s3;
    logic o; // filtered level
  } sync_t;
  sync_t st, nx;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    nx.s1 = pin_in;
    nx.s2 = st.s1;
    nx.s3 = st.s2;
    // a change counts only once two later stages agree
    if (st.s2 == st.s3) begin
      nx.o = st.s3;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= {4{`LINE_IDLE}};
    end else if (clk_en) begin
      st <= nx;
    end
  end

  assign line_out = st.o;

  property p_agree;
    @(posedge mclk) disable iff (!reset_n)
    (st.s2 != st.s3) |=> $stable(st.o);
  endproperty
  a_agree: assert property (p_agree) else $error("sync output moved on disagree"); // [R26]
endmodule // line_sync

// >>> multimode_serial_port.sv
/*
  multimode serial port: registers, transmitter, receiver.
  assumes: single mclk domain, plain register port with read data one
  cycle after the read strobe, rxd pin driven outside via rxd_oe.
*/
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module multimode_serial_port (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic clk_en,
  input wire serial_port_pkg::byte_t addr,
  input wire serial_port_pkg::byte_t wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output serial_port_pkg::byte_t rdata,
  input wire logic rxd_in,
  output logic rxd_out,
  output logic rxd_oe,
  output logic txd_out,
  output logic rx_irq,
  output logic tx_irq
);
  import serial_port_pkg::*;

  // ----------------------------------------
  // state
  // ----------------------------------------
  typedef struct packed {
    byte_t ctl; // serial_control
    byte_t div; // rate_divisor
    byte_t rbuf; // receive buffer
    logic rx_done; // rx_done_flag
    logic tx_done; // tx_done_flag
    byte_t rdata; // read data register
    logic rx_irq;
    logic tx_irq;
    logic txd; // txd pin, also the shift clock
    logic rxd_o; // shift mode data out
    logic rxd_oe;
    logic tx_act; // transmitter busy
    logic [10:0] tx_sh; // transmit frame shifter
    logic [3:0] tx_bit; // bit index in frame
    logic [3:0] tx_tk; // tick within bit
    rx_state_t rx_st;
    byte_t rx_sh; // receive shifter
    logic [3:0] rx_bit;
    logic [3:0] rx_tk;
  } core_t;
  core_t st, nx;

  logic [1:0] mode; // current operating mode
  logic m0; // shift mode
  logic wr_buf; // buffer write this cycle
  logic rxs; // synchronised rxd level
  logic [3:0] stop_idx; // index of stop bit
  baud_if b();

  // mode decode [R1] [R2] [R3] [R4]
  assign mode = st.ctl[7:6];
  assign m0 = (mode == `MODE_SHIFT);
  assign wr_buf = wr_stb && (addr == `OFS_BUFFER);
  assign stop_idx = (mode == `MODE_8VAR) ? `STOP_IDX_8 : `STOP_IDX_9;
  assign b.divisor = st.div; // [R5]
  assign b.fixed = (mode == `MODE_9FIX); // [R6]

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  line_sync u_sync (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .pin_in(rxd_in),
    .line_out(rxs)
  );

  baud_gen u_rate (
    .mclk(mclk),
    .reset_n(reset_n),
    .clk_en(clk_en),
    .b(b.gen)
  );

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nx = st;
    nx.rdata = 8'h00;

    // register reads return state before this cycle's update
    if (rd_stb) begin
      unique case (addr)
        `OFS_CONTROL: nx.rdata = st.ctl;
        `OFS_BUFFER: nx.rdata = st.rbuf; // receive side [R7]
        `OFS_DIVISOR: nx.rdata = st.div;
        `OFS_PENDING: nx.rdata = {2'b00, st.rx_done, st.tx_done, 4'h0}; // [R16]
        default: nx.rdata = 8'h00; // unmapped reads zero
      endcase
    end

    // register writes; hardware sets below win over clears
    if (wr_stb) begin
      unique case (addr)
        `OFS_CONTROL: nx.ctl = wdata;
        `OFS_DIVISOR: nx.div = wdata;
        `OFS_PENDING: begin
          // writing 0 clears, writing 1 leaves alone [R22]
          if (!wdata[`PND_RX]) begin
            nx.rx_done = 1'b0;
          end
          if (!wdata[`PND_TX]) begin
            nx.tx_done = 1'b0;
          end
        end
        default: ; // buffer handled by transmitter
      endcase
    end

    // ----------------------------------------
    // transmitter
    // ----------------------------------------
    if (wr_buf) begin
      // any buffer write restarts the shifter [R9] [R7]
      nx.tx_act = 1'b1;
      nx.tx_bit = 4'h0;
      nx.tx_tk = 4'h0;
      nx.txd = 1'b0; // start bit, or shift clock low
      if (m0) begin
        // data out on rxd, clock on txd [R12]
        nx.tx_sh = {3'b111, wdata};
        nx.rxd_o = wdata[0];
        nx.rxd_oe = 1'b1;
        if (st.rx_st == RX_SYNC) begin
          nx.rx_st = RX_IDLE; // one pin cannot carry both ways
        end
      end else begin
        // hardware frames the byte [R13] [R14]
        nx.tx_sh = {1'b1, (mode == `MODE_8VAR) ? 1'b1 : st.ctl[`CTL_TX9], wdata, 1'b0};
      end
    end else if (st.tx_act && b.tick) begin
      nx.tx_tk = st.tx_tk + 4'h1;
      if (m0) begin
        // clock low for half a bit, then high
        nx.txd = (nx.tx_tk >= `TICK_RISE);
        if (st.tx_tk == `TICK_LAST) begin
          nx.tx_sh = {1'b1, st.tx_sh[10:1]};
          nx.tx_bit = st.tx_bit + 4'h1;
          nx.rxd_o = st.tx_sh[1];
          if (st.tx_bit == `M0_LAST_BIT) begin
            // 8th bit out: stop clocking, idle high [R20] [R27]
            nx.tx_act = 1'b0;
            nx.tx_done = 1'b1;
            nx.txd = 1'b1;
            nx.rxd_oe = 1'b0;
          end
        end
      end else if (st.tx_tk == `TICK_LAST) begin
        nx.tx_sh = {1'b1, st.tx_sh[10:1]};
        nx.tx_bit = st.tx_bit + 4'h1;
        nx.txd = st.tx_sh[1];
        if (st.tx_bit + 4'h1 == stop_idx) begin
          nx.tx_done = 1'b1; // stop bit begins [R21]
        end
        if (st.tx_bit == stop_idx) begin
          nx.tx_act = 1'b0; // frame over, line stays high
          nx.txd = 1'b1;
        end
      end
    end

    // ----------------------------------------
    // receiver
    // ----------------------------------------
    unique case (st.rx_st)
      RX_IDLE: begin
        if (st.ctl[`CTL_RXEN]) begin
          if (m0) begin
            // shift mode waits for a cleared flag [R10]
            if (!st.rx_done && !st.tx_act && !wr_buf) begin
              nx.rx_st = RX_SYNC;
              nx.rx_tk = 4'h0;
              nx.rx_bit = 4'h0;
            end
          end else if (b.tick && !rxs) begin
            // falling edge of a start bit [R11]
            nx.rx_st = RX_START;
            nx.rx_tk = 4'h0;
          end
        end
      end
      RX_START: begin
        if (b.tick) begin
          nx.rx_tk = st.rx_tk + 4'h1;
          if (st.rx_tk == `TICK_MID) begin
            // recheck at the centre to reject glitches [R26]
            nx.rx_st = rxs ? RX_IDLE : RX_DATA;
            nx.rx_tk = 4'h0;
            nx.rx_bit = 4'h0;
          end
        end
      end
      RX_DATA: begin
        if (b.tick) begin
          nx.rx_tk = st.rx_tk + 4'h1;
          if (st.rx_tk == `TICK_LAST) begin
            // sixteen ticks on from a centre is the next centre [R26]
            nx.rx_bit = st.rx_bit + 4'h1;
            if (st.rx_bit != `RX_SAMPLES) begin
              nx.rx_sh = {rxs, st.rx_sh[7:1]}; // lsb first [R13]
            end else begin
              nx.rx_st = RX_HOLD;
              if (mode != `MODE_8VAR) begin
                // ninth bit kept, stop not checked [R15]
                nx.ctl[`CTL_RX9] = rxs;
              end
              // filter: ninth bit (or mode 1 stop) must be 1 [R25]
              if (!st.ctl[`CTL_FILTER] || rxs) begin
                // a still-unread byte is overwritten here [R8]
                nx.rbuf = st.rx_sh;
                nx.rx_done = 1'b1; // [R18] [R19]
              end
            end
          end
        end
      end
      RX_HOLD: begin
        // wait for a high line so a low ninth bit is no start
        if (rxs) begin
          nx.rx_st = RX_IDLE;
        end
      end
      RX_SYNC: begin
        if (b.tick) begin
          nx.rx_tk = st.rx_tk + 4'h1;
          nx.txd = (nx.rx_tk >= `TICK_RISE); // [R12]
          if (nx.rx_tk == `TICK_RISE) begin
            // sample on the rising shift clock
            nx.rx_sh = {rxs, st.rx_sh[7:1]};
            if (st.rx_bit == `M0_LAST_BIT) begin
              nx.rbuf = {rxs, st.rx_sh[7:1]};
              nx.rx_done = 1'b1; // [R17]
            end
          end
          if (st.rx_tk == `TICK_LAST) begin
            nx.rx_bit = st.rx_bit + 4'h1;
            if (st.rx_bit == `M0_LAST_BIT) begin
              nx.rx_st = RX_IDLE; // clock parks high [R27]
              nx.txd = 1'b1;
            end
          end
        end
      end
      default: nx.rx_st = RX_IDLE; // unused codes recover
    endcase

    // interrupt requests follow flag and enable [R23]
    nx.rx_irq = st.rx_done && st.ctl[`CTL_RIE];
    nx.tx_irq = st.tx_done && st.ctl[`CTL_TIE];
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      st <= '0;
      st.ctl <= `CTL_RESET; // mode 0, all off [R24]
      st.div <= `DIV_RESET;
      st.rbuf <= `BUF_RESET;
      st.txd <= `LINE_IDLE;
      st.rx_st <= RX_IDLE;
    end else if (clk_en) begin
      st <= nx;
    end
  end

  // outputs straight from the state flops
  assign rdata = st.rdata;
  assign rxd_out = st.rxd_o;
  assign rxd_oe = st.rxd_oe;
  assign txd_out = st.txd;
  assign rx_irq = st.rx_irq;
  assign tx_irq = st.tx_irq;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  sequence s_buf_write;
    wr_stb && (addr == `OFS_BUFFER) && clk_en;
  endsequence

  property p_tx_start;
    s_buf_write |=> st.tx_act ##0 (st.tx_bit == 4'h0);
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("write did not start tx"); // [R9]

  property p_rx_irq;
    (st.rx_done && st.ctl[`CTL_RIE] && clk_en) |=> rx_irq;
  endproperty
  a_rx_irq: assert property (p_rx_irq) else $error("rx request missing"); // [R23]

  property p_pend_hold;
    (st.rx_done && clk_en && !(wr_stb && addr == `OFS_PENDING && !wdata[`PND_RX]))
      |=> st.rx_done;
  endproperty
  a_pend_hold: assert property (p_pend_hold) else $error("rx flag lost"); // [R22]

  property p_ctl_reset;
    @(posedge mclk) disable iff (1'b0) !reset_n |=> (st.ctl == `CTL_RESET);
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control not cleared"); // [R24]

  property p_rd_buf;
    (rd_stb && addr == `OFS_BUFFER && clk_en) |=> (rdata == $past(st.rbuf));
  endproperty
  a_rd_buf: assert property (p_rd_buf) else $error("buffer read wrong"); // [R7]

  property p_clk_idle;
    (!st.tx_act && st.rx_st != RX_SYNC && !wr_buf && clk_en) |=> st.txd;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("txd not idle high"); // [R27]

  property p_stop_done;
    ($rose(st.tx_done) && st.ctl[7:6] != `MODE_SHIFT) |-> st.txd;
  endproperty
  a_stop_done: assert property (p_stop_done) else $error("tx flag off stop"); // [R21]

  property p_rx_start;
    (st.rx_st == RX_IDLE && !m0 && st.ctl[`CTL_RXEN] && b.tick && !rxs && clk_en)
      |=> (st.rx_st == RX_START);
  endproperty
  a_rx_start: assert property (p_rx_start) else $error("start bit missed"); // [R11]
endmodule // multimode_serial_port

// >>> serial_peer.sv
/*
  far-side serial device: sends and captures async frames, and acts as
  the shifted partner in shift mode.
  assumes: line idles high through a pull-up; the port drives the line
  only while dev_oe is high.
*/
`timescale 1ns/1ps
module serial_peer (
  input wire logic mclk,
  input wire logic txd,
  input wire logic dev_data,
  input wire logic dev_oe,
  output logic line
);
  // ----------------------------------------
  // line resolution
  // ----------------------------------------
  logic drv = 1'b1; // peer level; released means pull-up high
  int timeouts = 0; // waits that ran out of cycles
  assign line = dev_oe ? dev_data : drv;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  // bounded wait for a txd level, so a silent port cannot hang the run
  task automatic wait_txd(input logic lvl);
    int n;
    n = 0;
    while (txd !== lvl && n < 1000) begin
      @(posedge mclk);
      n++;
    end
    if (n == 1000) begin
      timeouts++;
    end
  endtask

  // async frame out: start, data lsb first, optional ninth, stop
  task automatic send(input logic [8:0] v, input int nb, input int per);
    logic [10:0] f;
    f = {1'b1, (nb == 9) ? v[8] : 1'b1, v[7:0], 1'b0};
    for (int i = 0; i < nb + 2; i++) begin
      @(posedge mclk);
      drv <= f[i];
      repeat (per - 1) @(posedge mclk);
    end
  endtask

  // async frame in, sampled at each bit centre
  task automatic grab(input int nb, input int per, output logic [10:0] f);
    f = '1;
    wait_txd(1'b0);
    repeat (per / 2) @(posedge mclk);
    for (int i = 0; i < nb + 2; i++) begin
      f[i] = txd;
      if (i < nb + 1) begin
        repeat (per) @(posedge mclk);
      end
    end
  endtask

  // shift mode capture of the resolved pin, so a missing enable reads high
  task automatic m0_grab(output logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      wait_txd(1'b0);
      wait_txd(1'b1);
      d[i] = line;
    end
  endtask

  // shift mode source: next bit goes out on each falling shift clock
  task automatic m0_send(input logic [7:0] v);
    drv <= v[0];
    for (int i = 0; i < 8; i++) begin
      wait_txd(1'b0);
      if (i > 0) begin
        drv <= v[i];
      end
      wait_txd(1'b1);
    end
    // hold past the port's input synchroniser, then release
    repeat (8) @(posedge mclk);
    drv <= 1'b1;
  endtask
endmodule // serial_peer

// >>> serial_port_defs.svh
/*
  constants of the multimode serial port: register offsets, bit fields,
  reset values, mode codes and bit-timing counts.
  assumes: included by bare name from every design file that needs it.
*/
// How it works
// R1: control bits 7:6 = 00 gives shift mode
// R2: 01 gives 8-bit async, variable rate
// R3: 10 gives 9-bit async, fixed rate
// R4: 11 gives 9-bit async, variable rate
// R5: rate = clock / (16 * (divisor + 1))
// R6: mode 2 rate = clock / 16, divisor ignored
// R7: buffer write loads tx, read returns rx
// R8: receiver runs ahead; unread byte overwritten
// R9: every buffer write starts a transmission
// R10: shift mode receive needs done clear, enable
// R11: async receive starts on low start bit
// R12: shift mode: clock on txd, data on rxd
// R13: mode 1 frame: start, 8 data, stop
// R14: 9-bit frame adds ninth bit from control
// R15: ninth bit stored in control bit 2
// R16: rx done is bit 5, tx done bit 4
// R17: shift mode rx done after 8th bit
// R18: mode 1 rx done at stop midpoint
// R19: 9-bit rx done at ninth bit midpoint
// R20: shift mode tx done after 8th bit
// R21: async tx done at stop bit start
// R22: done flags stay until software clears
// R23: interrupt request = done flag and enable
// R24: reset clears control register to zero
// R25: filter drops frames whose ninth bit is 0
// R26: async receiver samples at bit centre
// R27: shift clock idles high after eight clocks
`ifndef SERIAL_PORT_DEFS_SVH
`define SERIAL_PORT_DEFS_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define OFS_CONTROL 8'hF6
`define OFS_BUFFER 8'hF7
`define OFS_DIVISOR 8'hF8
`define OFS_PENDING 8'hF9

// ----------------------------------------
// control and pending fields
// ----------------------------------------
`define CTL_FILTER 5
`define CTL_RXEN 4
`define CTL_TX9 3
`define CTL_RX9 2
`define CTL_RIE 1
`define CTL_TIE 0
`define PND_RX 5
`define PND_TX 4

// ----------------------------------------
// reset values and mode codes
// ----------------------------------------
`define CTL_RESET 8'h00
`define DIV_RESET 8'h00
`define BUF_RESET 8'h00
`define LINE_IDLE 1'b1
`define MODE_SHIFT 2'h0
`define MODE_8VAR 2'h1
`define MODE_9FIX 2'h2
`define MODE_9VAR 2'h3

// ----------------------------------------
// bit timing, in ticks of sixteen per bit, and frame bit indices
// ----------------------------------------
`define TICK_LAST 4'hF
`define TICK_MID 4'h7
`define TICK_RISE 4'h8
`define RX_SAMPLES 4'h8
`define M0_LAST_BIT 4'h7
`define STOP_IDX_8 4'h9
`define STOP_IDX_9 4'hA

`endif

// >>> serial_port_pkg.sv
/*
  types shared by the serial port modules.
  assumes: nothing beyond a SystemVerilog compiler.
*/
package serial_port_pkg;
  // one register byte
  typedef logic [7:0] byte_t;
  // receiver sequencer states
  typedef enum logic [2:0] {RX_IDLE, RX_START, RX_DATA, RX_HOLD, RX_SYNC} rx_state_t;
endpackage

// >>> tb_multimode_serial_port.sv
/*
  self-checking bench for the multimode serial port.
  assumes: serial_peer on the far side; divisor 01 gives 32 cycles a bit.
*/
`timescale 1ns/1ps
`include "serial_port_defs.svh"
module tb_multimode_serial_port;
  import serial_port_pkg::*;
  // ----------------------------------------
  // stimulus and observation
  // ----------------------------------------
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic clk_en = 1'b1; // low freezes the port
  byte_t addr = 8'h00;
  byte_t wdata = 8'h00;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  byte_t rdata;
  logic rxd_line, rxd_out, rxd_oe, txd_out, rx_irq, tx_irq;
  int fail_count = 0;
  int num_checks = 0;
  int lows;
  logic [10:0] frame, exp;
  logic [7:0] m0;
  always #12.5 mclk = ~mclk; // 40 MHz

  multimode_serial_port dut_u (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .rxd_in(rxd_line), .rxd_out(rxd_out), .rxd_oe(rxd_oe), .txd_out(txd_out),
    .rx_irq(rx_irq), .tx_irq(tx_irq));
  serial_peer peer_u (.mclk(mclk), .txd(txd_out), .dev_data(rxd_out),
    .dev_oe(rxd_oe), .line(rxd_line));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [10:0] e, input logic [10:0] g);
    num_checks++;
    if (g !== e) begin
      $display("[FAIL] %s expected %h seen %h", what, e, g);
      fail_count++;
    end
  endtask

  task automatic wr(input byte_t a, input byte_t d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk);
    wr_stb <= 1'b0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input byte_t a, input byte_t e, input string what);
    @(posedge mclk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk);
    rd_stb <= 1'b0;
    @(posedge mclk);
    chk(what, {3'b000, e}, {3'b000, rdata});
  endtask

  task automatic conclude;
    if (fail_count == 0 && num_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
    chk("txd idle", 11'h001, {10'h000, txd_out});
    rd(`OFS_CONTROL, 8'h00, "control reset");
    rd(`OFS_PENDING, 8'h00, "pending reset");
    rd(8'hF5, 8'h00, "unmapped read");
    wr(8'hF5, 8'hFF);
    rd(`OFS_CONTROL, 8'h00, "control after stray write");
    wr(`OFS_DIVISOR, 8'h01);
    rd(`OFS_DIVISOR, 8'h01, "divisor");
    // a write while frozen must be lost
    clk_en <= 1'b0;
    wr(`OFS_DIVISOR, 8'h07);
    clk_en <= 1'b1;
    rd(`OFS_DIVISOR, 8'h01, "divisor frozen");
    // async transmit in modes 1, 2, 3; mode 2 must ignore the divisor
    for (int m = 1; m < 4; m++) begin
      wr(`OFS_PENDING, 8'h00);
      wr(`OFS_CONTROL, {m[1:0], 6'h01} | ((m == 3) ? 8'h08 : 8'h00));
      fork
        wr(`OFS_BUFFER, 8'hA5 ^ m[7:0]);
        peer_u.grab((m == 1) ? 8 : 9, (m == 2) ? 16 : 32, frame);
      join
      exp = {2'b11, 8'hA5 ^ m[7:0], 1'b0};
      exp[9] = (m != 2);
      chk("async tx frame", exp, frame);
      rd(`OFS_PENDING, 8'h10, "tx done at stop");
    end
    chk("tx irq set", 11'h001, {10'h000, tx_irq});
    repeat (200) @(posedge mclk);
    rd(`OFS_PENDING, 8'h10, "tx done held");
    wr(`OFS_PENDING, 8'h20);
    rd(`OFS_PENDING, 8'h00, "tx done cleared");
    chk("tx irq clear", 11'h000, {10'h000, tx_irq});
    // mode 1 receive, then two frames with no read between
    wr(`OFS_CONTROL, 8'h52);
    peer_u.send(9'h03C, 8, 32);
    rd(`OFS_PENDING, 8'h20, "rx done by stop");
    chk("rx irq set", 11'h001, {10'h000, rx_irq});
    rd(`OFS_BUFFER, 8'h3C, "mode 1 rx byte");
    peer_u.send(9'h011, 8, 32);
    peer_u.send(9'h022, 8, 32);
    rd(`OFS_BUFFER, 8'h22, "overrun keeps newest");
    // mode 1 with the filter: a low stop bit drops the frame
    wr(`OFS_PENDING, 8'h00);
    wr(`OFS_CONTROL, 8'h72);
    peer_u.send(9'h044, 9, 32);
    rd(`OFS_PENDING, 8'h00, "bad stop dropped");
    // mode 3 receive with the filter on
    wr(`OFS_PENDING, 8'h00);
    wr(`OFS_CONTROL, 8'hF2);
    peer_u.send(9'h055, 9, 32);
    rd(`OFS_PENDING, 8'h00, "filtered frame flag");
    rd(`OFS_BUFFER, 8'h22, "filtered frame buffer");
    peer_u.send(9'h1AA, 9, 32);
    rd(`OFS_PENDING, 8'h20, "rx done at ninth");
    rd(`OFS_CONTROL, 8'hF6, "ninth bit stored");
    rd(`OFS_BUFFER, 8'hAA, "mode 3 rx byte");
    // shift mode transmit
    wr(`OFS_PENDING, 8'h00);
    wr(`OFS_CONTROL, 8'h00);
    fork
      wr(`OFS_BUFFER, 8'h5A);
      peer_u.m0_grab(m0);
    join
    chk("mode 0 tx byte", 11'h05A, {3'b000, m0});
    repeat (40) @(posedge mclk);
    rd(`OFS_PENDING, 8'h10, "mode 0 tx done");
    chk("shift clock idle", 11'h001, {10'h000, txd_out});
    chk("data pin released", 11'h000, {10'h000, rxd_oe});
    // shift mode receive; no new shift clocks while rx done stays set
    wr(`OFS_PENDING, 8'h00);
    fork
      wr(`OFS_CONTROL, 8'h10);
      peer_u.m0_send(8'h96);
    join
    repeat (40) @(posedge mclk);
    rd(`OFS_PENDING, 8'h20, "mode 0 rx done");
    rd(`OFS_BUFFER, 8'h96, "mode 0 rx byte");
    lows = 0;
    repeat (300) begin
      @(posedge mclk);
      if (txd_out !== 1'b1) begin
        lows++;
      end
    end
    chk("no restart while done", 11'h000, lows[10:0]);
    chk("peer waits", 11'h000, peer_u.timeouts[10:0]);
    conclude();
  end
endmodule // tb_multimode_serial_port
